// >>> inc/ueb_pkg.sv
// Package with constants for the USB endpoint buffer controller.
package ueb_pkg;
  // ----------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------
  localparam logic [7:0] UEB_OFS_CFG = 8'h00;
  localparam logic [7:0] UEB_OFS_INUSE = 8'h04;
  localparam logic [7:0] UEB_OFS_SKIP = 8'h08;
  localparam logic [7:0] UEB_OFS_INTST = 8'h0C;
  localparam logic [7:0] UEB_OFS_CLKCTRL = 8'h10;
  localparam logic [7:0] UEB_OFS_CLKST = 8'h14;
  localparam logic [7:0] UEB_OFS_DEVCMD = 8'h18;
  localparam logic [7:0] UEB_OFS_STARTEN = 8'h1C;
  localparam logic [7:0] UEB_OFS_EPSEL = 8'h20;
  localparam logic [7:0] UEB_OFS_EPCS = 8'h24;
  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int UEB_CS_ACTIVE = 31;
  localparam int UEB_CS_DISABLED = 30;
  localparam int UEB_CS_STALL = 29;
  localparam int UEB_CS_TOGGLE_RESET = 28;
  localparam int UEB_CS_TOGGLE_VALUE = 27;
  localparam int UEB_CS_BC_LSB = 16;
  localparam int UEB_CLK_FORCE_BIT = 0;
  localparam int UEB_CLK_EDGE_BIT = 1;
  localparam int UEB_START_BIT = 19;
  localparam int UEB_WAKE_IRQ_LINE = 30;
  localparam int UEB_PKT_SHIFT = 6;
  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int UEB_CLK_MHZ = 100;
  localparam int UEB_SUSP_MS = 2;
  localparam int UEB_SUSP_CYC = UEB_SUSP_MS * 1000 * UEB_CLK_MHZ;
  localparam logic [1:0] UEB_RESP_OKAY = 2'b00;
  localparam logic [1:0] UEB_RESP_SLVERR = 2'b10;
endpackage : ueb_pkg

// >>> hw/ueb_ep_slot.sv
// One endpoint buffer slot: byte count, offset and active flag.
`timescale 1ns/100ps
module ueb_ep_slot
  import ueb_pkg::*;
#(
  parameter int BC_W = 10,
  parameter int OFS_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sw_wr,
  input wire logic sw_active,
  input wire logic [BC_W-1:0] sw_count,
  input wire logic [OFS_W-1:0] sw_offset,
  input wire logic pkt_done,
  input wire logic [BC_W-1:0] pkt_size,
  input wire logic pkt_short,
  input wire logic skip,
  output logic active,
  output logic [BC_W-1:0] byte_count,
  output logic [OFS_W-1:0] offset,
  output logic done_pulse
);
  logic [BC_W-1:0] bc_next;

  initial begin
    if (BC_W < 7 || BC_W > 16) $error("BC_W out of range");
  end

  assign bc_next = (pkt_size >= byte_count) ? '0 : byte_count - pkt_size;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active <= 1'b0;
      byte_count <= '0;
      offset <= '0;
      done_pulse <= 1'b0;
    end else if (ce) begin
      done_pulse <= 1'b0;
      if (sw_wr) begin
        active <= sw_active;
        byte_count <= sw_count;
        offset <= sw_offset;
      end else if (active && skip) begin
        active <= 1'b0;
      end else if (active && pkt_done) begin
        byte_count <= bc_next;
        offset <= offset + OFS_W'(pkt_size >> UEB_PKT_SHIFT);
        // finish on zero or short packet.
        if (bc_next == '0 || pkt_short) begin
          active <= 1'b0;
          done_pulse <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  property p_count_down;
    @(posedge aclk) disable iff (!aresetn)
    ce && active && pkt_done && !sw_wr && !skip && pkt_size < byte_count
    |=> byte_count == $past(byte_count) - $past(pkt_size);
  endproperty
  a_count_down: assert property (p_count_down) else $error("count not reduced");

  property p_finish;
    @(posedge aclk) disable iff (!aresetn)
    ce && active && pkt_done && !sw_wr && !skip && (pkt_short || pkt_size >= byte_count)
    |=> !active && done_pulse;
  endproperty
  a_finish: assert property (p_finish) else $error("buffer not finished");
endmodule : ueb_ep_slot

// >>> hw/ueb_top.sv
// Endpoint buffer control, suspend clock request and AXI4-Lite registers.
`timescale 1ns/100ps
// How it works
// - Config bit zero: single buffer, in-use bit picks the entry.
// - Active buffer keeps moving packets until byte count hits zero.
// - At zero count, clear active and set endpoint interrupt status.
// - Skip bit deactivates an active buffer early.
// - Config bit one: double buffer with entries zero and one.
// - In-use bit names buffer for the next token.
// - Finishing a buffer (zero count or short packet) in double mode toggles the in-use bit.
// - Software write to in-use bit forces that buffer.
// - STALL only when enabled, not active and stall set.
// - Clock force zero: clock request driven automatically.
// - Clock request drops 2 ms after suspend; status shows zero.
// - Control bit one: wake event on clock request rising edge.
// - Wake event goes out on interrupt line 30.
// - Start enable bit 19 makes clock request a wake source.
// - Remote wake: force clock, clear suspend, wait, release force.
// - Each good packet decrements byte count by its size.
// - Short OUT packet clears active, leaves remaining count.
// - Each good packet advances offset by size divided by 64.
module ueb_top
  import ueb_pkg::*;
#(
  parameter int NUM_EP = 4,
  parameter int BC_W = 10,
  parameter int SUSP_CYC = UEB_SUSP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic token_valid,
  input wire logic [1:0] token_ep,
  input wire logic pkt_done,
  input wire logic [BC_W-1:0] pkt_size,
  input wire logic pkt_short,
  input wire logic bus_suspend,
  input wire logic bus_activity,
  output logic stall_hs,
  output logic [1:0] buf_sel,
  output logic clock_request,
  output logic [31:0] irq_lines,
  output logic wake_request
);
  localparam int NB = 2 * NUM_EP;

  initial begin
    if (NUM_EP < 1 || NUM_EP > 4 || BC_W < 7 || BC_W > 11) $error("NUM_EP or BC_W out of range");
  end

  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  logic [NUM_EP-1:0] cfg_double_reg;
  logic [NUM_EP-1:0] in_use_reg;
  logic [NB-1:0] int_status_reg;
  logic [NB-1:0] disabled_reg;
  logic [NB-1:0] stall_reg;
  logic [NB-1:0] toggle_reg;
  logic [1:0] usb_clock_control_reg;
  logic device_suspend;
  logic start_enable;
  logic [2:0] ep_sel_reg;
  logic [31:0] susp_cnt_reg;
  logic need_clk_q;

  logic [NB-1:0] slot_active;
  logic [NB-1:0] slot_done;
  logic [BC_W-1:0] slot_bc [NB];
  logic [15:0] slot_ofs [NB];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel.
  // ----------------------------------------------------------------
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;

  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= UEB_RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > UEB_OFS_EPCS || aw_addr[1:0] != 2'b00) ?
                       UEB_RESP_SLVERR : UEB_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_go && aw_addr == ofs && w_strb == 4'hF;
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // Endpoint buffers.
  // ----------------------------------------------------------------
  logic [2:0] tok_slot;
  logic tok_slot_active;
  assign tok_slot = {token_ep, in_use_reg[token_ep]};
  assign tok_slot_active = slot_active[tok_slot];

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_slot
      logic sel_wr;
      logic skip_hit;
      assign sel_wr = wr_go && aw_addr == UEB_OFS_EPCS && w_strb == 4'hF && ep_sel_reg == 3'(gi);
      assign skip_hit = wr_go && aw_addr == UEB_OFS_SKIP && w_strb == 4'hF && w_data[gi/2] &&
                        in_use_reg[gi/2] == 1'(gi % 2);
      ueb_ep_slot #(.BC_W(BC_W), .OFS_W(16)) u_slot (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .sw_wr(sel_wr),
        .sw_active(w_data[UEB_CS_ACTIVE]),
        .sw_count(w_data[UEB_CS_BC_LSB +: BC_W]),
        .sw_offset(w_data[15:0]),
        .pkt_done(pkt_done && tok_slot == 3'(gi)),
        .pkt_size(pkt_size),
        .pkt_short(pkt_short),
        .skip(skip_hit),
        .active(slot_active[gi]),
        .byte_count(slot_bc[gi]),
        .offset(slot_ofs[gi]),
        .done_pulse(slot_done[gi])
      );
    end
  endgenerate

  // Buffer selection, status flags and endpoint flags.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_double_reg <= '0;
      in_use_reg <= '0;
      int_status_reg <= '0;
      disabled_reg <= '0;
      stall_reg <= '0;
      toggle_reg <= '0;
      ep_sel_reg <= 3'h0;
    end else if (ce) begin
      if (wr_hit(UEB_OFS_CFG)) cfg_double_reg <= w_data[NUM_EP-1:0];
      if (wr_hit(UEB_OFS_EPSEL)) ep_sel_reg <= w_data[2:0];
      if (wr_hit(UEB_OFS_EPCS)) begin
        disabled_reg[ep_sel_reg] <= w_data[UEB_CS_DISABLED];
        stall_reg[ep_sel_reg] <= w_data[UEB_CS_STALL];
        if (w_data[UEB_CS_TOGGLE_RESET])
          toggle_reg[ep_sel_reg] <= w_data[UEB_CS_TOGGLE_VALUE];
      end
      if (wr_hit(UEB_OFS_INUSE)) begin
        in_use_reg <= w_data[NUM_EP-1:0];
      end else begin
        for (int e = 0; e < NUM_EP; e++) begin
          if (cfg_double_reg[e] && slot_done[{e[1:0], in_use_reg[e]}])
            in_use_reg[e] <= !in_use_reg[e];
        end
      end
      // sticky status, set wins over clear.
      int_status_reg <= (wr_hit(UEB_OFS_INTST) ? int_status_reg & ~w_data[NB-1:0] :
                         int_status_reg) | slot_done;
      if (pkt_done && tok_slot_active) toggle_reg[tok_slot] <= !toggle_reg[tok_slot];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_hs <= 1'b0;
      buf_sel <= 2'b00;
    end else if (ce) begin
      stall_hs <= token_valid && !disabled_reg[tok_slot] && !tok_slot_active &&
                  stall_reg[tok_slot];
      buf_sel <= {token_valid, in_use_reg[token_ep]};
    end
  end

  // ----------------------------------------------------------------
  // Suspend and clock request.
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_clock_control_reg <= 2'b00;
      device_suspend <= 1'b0;
      start_enable <= 1'b0;
      susp_cnt_reg <= '0;
      clock_request <= 1'b1;
      need_clk_q <= 1'b1;
      irq_lines <= 32'h0000_0000;
      wake_request <= 1'b0;
    end else if (ce) begin
      if (wr_hit(UEB_OFS_CLKCTRL)) usb_clock_control_reg <= w_data[1:0];
      if (wr_hit(UEB_OFS_STARTEN)) start_enable <= w_data[UEB_START_BIT];
      // software may clear suspend for remote wake.
      if (bus_suspend) device_suspend <= 1'b1;
      else if (wr_hit(UEB_OFS_DEVCMD)) device_suspend <= w_data[0];
      else if (bus_activity) device_suspend <= 1'b0;
      if (!device_suspend || bus_activity) susp_cnt_reg <= '0;
      else if (susp_cnt_reg < 32'(SUSP_CYC)) susp_cnt_reg <= susp_cnt_reg + 32'h1;
      clock_request <= usb_clock_control_reg[UEB_CLK_FORCE_BIT] || bus_activity ||
                       !(device_suspend && susp_cnt_reg >= 32'(SUSP_CYC));
      need_clk_q <= clock_request;
      irq_lines[UEB_WAKE_IRQ_LINE] <= usb_clock_control_reg[UEB_CLK_EDGE_BIT] ?
                                      clock_request && !need_clk_q : clock_request;
      wake_request <= start_enable && clock_request && !need_clk_q;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel.
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      UEB_OFS_CFG: rd_val[NUM_EP-1:0] = cfg_double_reg;
      UEB_OFS_INUSE: rd_val[NUM_EP-1:0] = in_use_reg;
      UEB_OFS_INTST: rd_val[NB-1:0] = int_status_reg;
      UEB_OFS_CLKCTRL: rd_val[1:0] = usb_clock_control_reg;
      UEB_OFS_CLKST: rd_val[0] = clock_request;
      UEB_OFS_DEVCMD: rd_val[0] = device_suspend;
      UEB_OFS_STARTEN: rd_val[UEB_START_BIT] = start_enable;
      UEB_OFS_EPSEL: rd_val[2:0] = ep_sel_reg;
      UEB_OFS_EPCS: begin
        rd_val[UEB_CS_ACTIVE] = slot_active[ep_sel_reg];
        rd_val[UEB_CS_DISABLED] = disabled_reg[ep_sel_reg];
        rd_val[UEB_CS_STALL] = stall_reg[ep_sel_reg];
        rd_val[UEB_CS_TOGGLE_VALUE] = toggle_reg[ep_sel_reg];
        rd_val[UEB_CS_BC_LSB +: BC_W] = slot_bc[ep_sel_reg];
        rd_val[15:0] = slot_ofs[ep_sel_reg];
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= UEB_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= (s_axi_araddr > UEB_OFS_EPCS || s_axi_araddr[1:0] != 2'b00) ?
                       UEB_RESP_SLVERR : UEB_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  property p_stall;
    @(posedge aclk) disable iff (!aresetn)
    ce && token_valid && slot_active[tok_slot] |=> !stall_hs;
  endproperty
  a_stall: assert property (p_stall) else $error("stall while active");
  property p_done_sets_status;
    @(posedge aclk) disable iff (!aresetn)
    ce && |slot_done |=> (int_status_reg & $past(slot_done)) == $past(slot_done);
  endproperty
  a_done_sets_status: assert property (p_done_sets_status) else $error("status lost");
  for (genvar ge = 0; ge < NUM_EP; ge++) begin : g_chk
    property p_toggle_inuse;
      @(posedge aclk) disable iff (!aresetn)
      ce && cfg_double_reg[ge] && slot_done[{2'(ge), in_use_reg[ge]}] && !wr_hit(UEB_OFS_INUSE)
      |=> in_use_reg[ge] != $past(in_use_reg[ge]);
    endproperty
    a_toggle_inuse: assert property (p_toggle_inuse) else $error("no buffer switch");
  end
  property p_clkreq_force;
    @(posedge aclk) disable iff (!aresetn)
    ce && usb_clock_control_reg[0] |=> clock_request;
  endproperty
  a_clkreq_force: assert property (p_clkreq_force) else $error("forced clock dropped");
endmodule : ueb_top

// >>> tb/ueb_host_model.sv
// Behavioural USB host that sends tokens, packets and bus state changes.
`timescale 1ns/100ps
module ueb_host_model
  import ueb_pkg::*;
#(
  parameter int BC_W = 10
) (
  input wire logic aclk,
  output logic token_valid,
  output logic [1:0] token_ep,
  output logic pkt_done,
  output logic [BC_W-1:0] pkt_size,
  output logic pkt_short,
  output logic bus_suspend,
  output logic bus_activity
);
  logic busy = 1'b0;
  initial begin
    token_valid = 1'b0;
    token_ep = 2'h0;
    pkt_done = 1'b0;
    pkt_size = '0;
    pkt_short = 1'b0;
    bus_suspend = 1'b0;
    bus_activity = 1'b0;
  end
  // Unqualified lines wander so that no stale value is ever trusted.
  always @(posedge aclk) begin
    if (!busy) begin
      token_ep <= token_ep + 2'h1;
      pkt_size <= BC_W'($urandom);
    end
  end
  task automatic token(input logic [1:0] ep);
    busy = 1'b1;
    token_valid <= 1'b1;
    token_ep <= ep;
    @(posedge aclk);
    token_valid <= 1'b0;
    busy = 1'b0;
  endtask : token
  // The data stage follows the token promptly or after a few idle cycles.
  task automatic packet(input logic [1:0] ep, input logic [BC_W-1:0] sz, input logic sh);
    int gap;
    gap = $urandom % 4;
    token(ep);
    busy = 1'b1;
    repeat (gap) @(posedge aclk);
    pkt_done <= 1'b1;
    pkt_size <= sz;
    pkt_short <= sh;
    @(posedge aclk);
    pkt_done <= 1'b0;
    pkt_short <= 1'b0;
    busy = 1'b0;
  endtask : packet
  task automatic suspend();
    bus_suspend <= 1'b1;
    @(posedge aclk);
    bus_suspend <= 1'b0;
  endtask : suspend
  task automatic activity(input int n);
    bus_activity <= 1'b1;
    repeat (n) @(posedge aclk);
    bus_activity <= 1'b0;
  endtask : activity
endmodule : ueb_host_model

// >>> tb/ueb_top_tb_top.sv
// Self-checking bench for the endpoint buffer controller.
`timescale 1ns/100ps
module ueb_top_tb_top
  import ueb_pkg::*;
;
  localparam int BW = 10;
  localparam int SC = 20;
  localparam logic [1:0] OK = UEB_RESP_OKAY;
  logic aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic aresetn = 1'b0, ce = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, irq_lines;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, token_ep, buf_sel;
  logic token_valid, pkt_done, pkt_short, bus_suspend, bus_activity;
  logic stall_hs, clock_request, wake_request;
  logic [BW-1:0] pkt_size;
  int num_errors = 0, comparisons = 0, cyc = 0, wake_n = 0, irq_n = 0;
  logic [33:0] exp_q[$], msk_q[$];
  logic [1:0] bexp_q[$];
  logic [31:0] stv[4] = '{32'h2000_0000, 32'h6000_0000, 32'h0, 32'hA040_0000};
  logic [3:0] stx = 4'b0001;

  ueb_top #(.NUM_EP(4), .BC_W(BW), .SUSP_CYC(SC)) dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .token_valid, .token_ep, .pkt_done, .pkt_size,
    .pkt_short, .bus_suspend, .bus_activity, .stall_hs, .buf_sel, .clock_request,
    .irq_lines, .wake_request);
  ueb_host_model #(.BC_W(BW)) host (.aclk, .token_valid, .token_ep, .pkt_done,
    .pkt_size, .pkt_short, .bus_suspend, .bus_activity);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // Comparison, verdict and bus tasks.
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input logic [33:0] m);
    comparisons++;
    if ((seen & m) !== (exp & m)) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen & m, exp & m);
    end
  endtask : chk
  task automatic chk1(input logic seen, input logic exp);
    chk({33'h0, seen}, {33'h0, exp}, 34'h1);
  endtask : chk1
  function automatic logic [31:0] cs(input logic a, input logic d, input logic s,
      input logic [9:0] n, input logic [15:0] o);
    return {a, d, s, 3'b000, n, o};
  endfunction : cs
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] br);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bexp_q.push_back(br);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] e,
      input logic [31:0] m);
    exp_q.push_back({r, e});
    msk_q.push_back({2'b11, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic tok(input logic [1:0] ep, input logic st, input logic [1:0] bs);
    host.token(ep);
    @(posedge aclk);
    chk1(stall_hs, st);
    chk({32'h0, buf_sel}, {32'h0, bs}, 34'h3);
  endtask : tok
  // Answers are compared in request order as they appear.
  always @(posedge aclk) begin
    cyc++;
    if (wake_request === 1'b1) wake_n++;
    if (irq_lines[30] === 1'b1) irq_n++;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front(), msk_q.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      chk({32'h0, s_axi_bresp}, {32'h0, bexp_q.pop_front()}, 34'h3);
    end
    if (cyc == 30000) begin
      num_errors++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    int rem, sz, ofs, w0, i0;
    void'($urandom(378));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(UEB_OFS_CFG, OK, 32'h0, 32'hF);
    rd(UEB_OFS_CLKCTRL, OK, 32'h0, 32'h3);
    rd(UEB_OFS_CLKST, OK, 32'h1, 32'h1);
    rd(8'h28, UEB_RESP_SLVERR, 32'h0, 32'h0);
    rd(8'h02, UEB_RESP_SLVERR, 32'h0, 32'h0);
    wr(8'h30, 32'h1, UEB_RESP_SLVERR);
    wr(UEB_OFS_INUSE, 32'h0, OK);
    wr(UEB_OFS_EPSEL, 32'h2, OK);
    rem = 65 + $urandom % 200;
    ofs = 0;
    wr(UEB_OFS_EPCS, cs(1'b1, 1'b0, 1'b0, 10'(rem), 16'h0), OK);
    while (rem > 0) begin
      sz = (rem > 64) ? 64 : rem;
      host.packet(2'h1, 10'(sz), 1'b0);
      rem -= sz;
      ofs += sz / 64;
      rd(UEB_OFS_EPCS, OK, cs(rem != 0, 1'b0, 1'b0, 10'(rem), 16'(ofs)), 32'hE3FF_FFFF);
    end
    rd(UEB_OFS_INTST, OK, 32'h4, 32'h4);
    wr(UEB_OFS_INTST, 32'h4, OK);
    wr(UEB_OFS_EPCS, cs(1'b1, 1'b0, 1'b0, 10'd100, 16'h0), OK);
    host.packet(2'h1, 10'd10, 1'b1);
    rd(UEB_OFS_EPCS, OK, cs(1'b0, 1'b0, 1'b0, 10'd90, 16'h0), 32'hE3FF_FFFF);
    wr(UEB_OFS_EPCS, cs(1'b1, 1'b0, 1'b0, 10'd200, 16'h0), OK);
    host.packet(2'h1, 10'd64, 1'b0);
    wr(UEB_OFS_SKIP, 32'h2, OK);
    rd(UEB_OFS_EPCS, OK, cs(1'b0, 1'b0, 1'b0, 10'd136, 16'h1), 32'h83FF_FFFF);
    wr(UEB_OFS_CFG, 32'h4, OK);
    for (int b = 4; b < 6; b++) begin
      wr(UEB_OFS_EPSEL, 32'(b), OK);
      wr(UEB_OFS_EPCS, cs(1'b1, 1'b0, 1'b0, 10'd64, 16'h0), OK);
    end
    tok(2'h2, 1'b0, 2'b10);
    host.packet(2'h2, 10'd64, 1'b0);
    rd(UEB_OFS_INUSE, OK, 32'h4, 32'h4);
    tok(2'h2, 1'b0, 2'b11);
    wr(UEB_OFS_INUSE, 32'h0, OK);
    tok(2'h2, 1'b0, 2'b10);
    wr(UEB_OFS_INUSE, 32'h4, OK);
    host.packet(2'h2, 10'd64, 1'b0);
    rd(UEB_OFS_INUSE, OK, 32'h0, 32'h4);
    rd(UEB_OFS_INTST, OK, 32'h30, 32'h30);
    for (int b = 4; b < 6; b++) begin
      wr(UEB_OFS_EPSEL, 32'(b), OK);
      wr(UEB_OFS_EPCS, 32'h0, OK);
    end
    rd(UEB_OFS_INUSE, OK, 32'h0, 32'h4);
    wr(UEB_OFS_EPSEL, 32'h4, OK);
    rd(UEB_OFS_EPCS, OK, 32'h0800_0000, 32'h0800_0000);
    wr(UEB_OFS_EPCS, 32'h1000_0000, OK);
    rd(UEB_OFS_EPCS, OK, 32'h0, 32'h2800_0000);
    wr(UEB_OFS_EPSEL, 32'h6, OK);
    for (int k = 0; k < 4; k++) begin
      wr(UEB_OFS_EPCS, stv[k], OK);
      tok(2'h3, stx[k], 2'b10);
    end
    wr(UEB_OFS_SKIP, 32'h8, OK);
    tok(2'h3, 1'b1, 2'b10);
    wr(UEB_OFS_EPCS, 32'h1000_0000, OK);
    tok(2'h3, 1'b0, 2'b10);
    wr(UEB_OFS_EPCS, 32'h6000_0000, OK);
    tok(2'h3, 1'b0, 2'b10);
    host.suspend();
    rd(UEB_OFS_DEVCMD, OK, 32'h1, 32'h1);
    chk1(clock_request, 1'b1);
    repeat (SC + 10) @(posedge aclk);
    chk1(clock_request, 1'b0);
    rd(UEB_OFS_CLKST, OK, 32'h0, 32'h1);
    wr(UEB_OFS_STARTEN, 32'h0008_0000, OK);
    wr(UEB_OFS_CLKCTRL, 32'h2, OK);
    w0 = wake_n;
    i0 = irq_n;
    host.activity(5);
    repeat (5) @(posedge aclk);
    chk1(clock_request, 1'b1);
    chk(34'(wake_n - w0), 34'h1, 34'h3FFFF_FFFF);
    chk(34'(irq_n - i0), 34'h1, 34'h3FFFF_FFFF);
    chk({2'b00, irq_lines}, 34'h0, 34'h0BFFF_FFFF);
    rd(UEB_OFS_DEVCMD, OK, 32'h0, 32'h1);
    wr(UEB_OFS_CLKCTRL, 32'h0, OK);
    host.suspend();
    repeat (SC + 10) @(posedge aclk);
    chk1(clock_request, 1'b0);
    wr(UEB_OFS_CLKCTRL, 32'h1, OK);
    repeat (2) @(posedge aclk);
    chk1(clock_request, 1'b1);
    wr(UEB_OFS_DEVCMD, 32'h0, OK);
    rd(UEB_OFS_DEVCMD, OK, 32'h0, 32'h1);
    wr(UEB_OFS_CLKCTRL, 32'h0, OK);
    repeat (SC + 10) @(posedge aclk);
    chk1(clock_request, 1'b1);
    ce <= 1'b0;
    host.suspend();
    @(posedge aclk);
    ce <= 1'b1;
    rd(UEB_OFS_DEVCMD, OK, 32'h0, 32'h1);
    complete_run();
  end
endmodule : ueb_top_tb_top
